// ---- pvc_pkg.sv ----
package pvc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PVC_OFS_OPERATION  = 8'h00;
    localparam logic [7:0] PVC_OFS_VOUT_CMD   = 8'h04;
    localparam logic [7:0] PVC_OFS_SCALE_LOOP = 8'h08;
    localparam logic [7:0] PVC_OFS_MARGIN_HI  = 8'h0C;
    localparam logic [7:0] PVC_OFS_MARGIN_LO  = 8'h10;
    localparam logic [7:0] PVC_OFS_OV_FAULT   = 8'h14;
    localparam logic [7:0] PVC_OFS_UV_FAULT   = 8'h18;
    localparam logic [7:0] PVC_OFS_OV_WARN    = 8'h1C;
    localparam logic [7:0] PVC_OFS_UV_WARN    = 8'h20;
    localparam logic [7:0] PVC_OFS_TRAN_RATE  = 8'h24;
    localparam logic [7:0] PVC_OFS_PWM_MODE   = 8'h28;
    localparam logic [7:0] PVC_OFS_COMMON     = 8'h2C;
    localparam logic [7:0] PVC_OFS_VOUT_MAX   = 8'h30;
    localparam logic [7:0] PVC_OFS_ABS_CEIL   = 8'h34;
    localparam logic [7:0] PVC_OFS_SENSE      = 8'h38;
    localparam logic [7:0] PVC_OFS_IRQ_STAT   = 8'h3C;
    localparam logic [7:0] PVC_OFS_IRQ_MASK   = 8'h40;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PVC_OP_ON_BIT       = 7;
    localparam int PVC_OP_MARGIN_LSB   = 4;
    localparam logic [1:0] PVC_MARGIN_NONE = 2'h0;
    localparam logic [1:0] PVC_MARGIN_LOW  = 2'h1;
    localparam logic [1:0] PVC_MARGIN_HIGH = 2'h2;
    localparam int PVC_PWM_SLAVE_BIT   = 4;
    localparam int PVC_PWM_SERVO_BIT   = 6;
    localparam int PVC_COM_BUSY_A_BIT  = 6;
    localparam int PVC_COM_BUSY_B_BIT  = 5;
    localparam int PVC_IRQ_DONE_BIT    = 0;
    localparam int PVC_IRQ_OV_BIT      = 1;
    localparam int PVC_IRQ_UV_BIT      = 2;
    localparam int PVC_IRQ_REFUSE_BIT  = 3;
    localparam int PVC_IRQ_W           = 4;

    // ------------------------------------------------------------
    // Voltages in mV, scale loop is unsigned 8.8
    // ------------------------------------------------------------
    localparam logic [15:0] PVC_FB_NOM_MV     = 16'h0190;
    localparam logic [15:0] PVC_VCMD_MIN_MV   = 16'h012C;
    localparam logic [15:0] PVC_VCMD_MAX_MV   = 16'h0D7A;
    localparam logic [15:0] PVC_FIXED_MAX_MV  = 16'h0EA6;
    localparam logic [15:0] PVC_ABS_CEIL_MV   = 16'h0EA6;
    localparam logic [15:0] PVC_FB_SPAN_MV    = 16'h0D7A;
    localparam logic [15:0] PVC_SCALE_UNITY   = 16'h0100;
    localparam int          PVC_SCALE_FRAC    = 8;
    localparam logic [15:0] PVC_PCT5_DIV      = 16'h0014;
    localparam logic [15:0] PVC_PCT10_DIV     = 16'h000A;
    localparam logic [15:0] PVC_MARGIN_HI_RST = PVC_FB_NOM_MV + PVC_FB_NOM_MV / PVC_PCT5_DIV;
    localparam logic [15:0] PVC_MARGIN_LO_RST = PVC_FB_NOM_MV - PVC_FB_NOM_MV / PVC_PCT5_DIV;
    localparam logic [15:0] PVC_OV_FAULT_RST  = PVC_FB_NOM_MV + PVC_FB_NOM_MV / PVC_PCT10_DIV;
    localparam logic [15:0] PVC_UV_FAULT_RST  = PVC_FB_NOM_MV - PVC_FB_NOM_MV / PVC_PCT10_DIV;
    localparam logic [15:0] PVC_OV_WARN_RST   = 16'hFFFF;
    localparam logic [15:0] PVC_UV_WARN_RST   = 16'h0000;
    localparam logic [15:0] PVC_RATE_RST      = 16'h0001;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int PVC_CLK_MHZ        = 100;
    localparam int PVC_RECALC_MS      = 500;
    localparam int PVC_RECALC_CYCLES  = PVC_RECALC_MS * 1000 * PVC_CLK_MHZ;

    typedef enum logic [1:0] {
        PVC_RC_IDLE = 2'b00,
        PVC_RC_CALC = 2'b01,
        PVC_RC_WAIT = 2'b11
    } pvc_rc_state_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
    } pvc_dphase_t;

endpackage

// ---- pvc_recalc.sv ----
`timescale 1ns/1ps
module pvc_recalc import pvc_pkg::*;
#(
    parameter int RECALC_CYCLES = PVC_RECALC_CYCLES,
    parameter bit FIXED_MAX     = 1'b0
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [15:0] scale,
    output logic             busy_r,
    output logic             done_r,
    output logic [15:0]      vout_max_r
);

    pvc_rc_state_t state_r;
    logic [31:0]   cnt_r;
    logic [31:0]   prod;

    assign prod = {16'h0000, scale} * {16'h0000, PVC_FB_SPAN_MV};

    // ------------------------------------------------------------
    // Sequencer; limit is held stable outside the busy window
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r    <= PVC_RC_IDLE;
            cnt_r      <= 32'h0000_0000;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
            vout_max_r <= FIXED_MAX ? PVC_FIXED_MAX_MV : PVC_ABS_CEIL_MV;
        end
        else
        begin
            done_r <= 1'b0;
            case (state_r)
                PVC_RC_IDLE:
                begin
                    if (start)
                    begin
                        state_r <= PVC_RC_CALC;
                        busy_r  <= 1'b1; // see [RULE_18]
                    end
                end
                PVC_RC_CALC:
                begin
                    if (FIXED_MAX)
                        vout_max_r <= PVC_FIXED_MAX_MV; // see [RULE_15]
                    else if (prod[31:PVC_SCALE_FRAC] > {8'h00, PVC_ABS_CEIL_MV})
                        vout_max_r <= PVC_ABS_CEIL_MV; // see [RULE_14]
                    else
                        vout_max_r <= prod[PVC_SCALE_FRAC +: 16];
                    cnt_r   <= 32'h0000_0000;
                    state_r <= PVC_RC_WAIT;
                end
                PVC_RC_WAIT:
                begin
                    // Worst case budget, so software never sees an early finish
                    if (cnt_r >= RECALC_CYCLES - 2)
                    begin
                        state_r <= PVC_RC_IDLE;
                        busy_r  <= 1'b0; // see [RULE_09] [RULE_18]
                        done_r  <= 1'b1;
                    end
                    else
                        cnt_r <= cnt_r + 32'h0000_0001;
                end
                default:
                begin
                    state_r <= PVC_RC_IDLE;
                    busy_r  <= 1'b0;
                end
            endcase
        end
    end

endmodule

// ---- pvc_ctrl.sv ----
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] Margin requests accepted in divider mode
// [RULE_02] Defaults: UV -10, margins +-5, OV +10 percent
// [RULE_03] Default warning limits never trip
// [RULE_04] Divider mode ramps the feedback node
// [RULE_05] Host keeps servo bit clear; resets clear
// [RULE_06] Slave phase bit drives external compensation
// [RULE_07] Sense pins feed regulation and telemetry
// [RULE_08] Host: off, scale, wait, command, limits, on
// [RULE_09] Busy flags up to 500 ms after scale write
// [RULE_10] Host changes scale only with rail off
// [RULE_11] Output commands deferred while recalculating
// [RULE_12] Host waits for flags before output commands
// [RULE_13] Output command clamped 300 mV to limit; code caps it at the lower of the limit and 3450 mV
// [RULE_14] Read-only limit from scale, capped by ceiling
// [RULE_15] Fixed variant reports 3.75 V limit
// [RULE_16] Direct mode ramps the output itself
// [RULE_17] Servo enable writable anytime
// [RULE_18] Both busy flags set and clear together
module pvc_ctrl import pvc_pkg::*;
#(
    parameter int RECALC_CYCLES = PVC_RECALC_CYCLES,
    parameter bit FIXED_MAX     = 1'b0
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        run_pin,
    input  wire logic        step_clk,
    input  wire logic [15:0] sense_adc,
    output logic             irq,
    output logic             rail_en,
    output logic [15:0]      ref_target,
    output logic             ref_at_output,
    output logic             slave_phase,
    output logic             servo_en
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic is_vout_reg(input logic [7:0] a);
        is_vout_reg = (a == PVC_OFS_VOUT_CMD)  || (a == PVC_OFS_SCALE_LOOP) ||
                      (a == PVC_OFS_MARGIN_HI) || (a == PVC_OFS_MARGIN_LO)  ||
                      (a == PVC_OFS_OV_FAULT)  || (a == PVC_OFS_UV_FAULT)   ||
                      (a == PVC_OFS_OV_WARN)   || (a == PVC_OFS_UV_WARN)    ||
                      (a == PVC_OFS_TRAN_RATE);
    endfunction

    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        if (v < lo)
            clamp = lo;
        else if (v > hi)
            clamp = hi;
        else
            clamp = v;
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]            operation_r;
    logic [15:0]           vout_cmd_r;
    logic [15:0]           scale_loop_r;
    logic [15:0]           margin_hi_r;
    logic [15:0]           margin_lo_r;
    logic [15:0]           ov_fault_r;
    logic [15:0]           uv_fault_r;
    logic [15:0]           ov_warn_r;
    logic [15:0]           uv_warn_r;
    logic [15:0]           tran_rate_r;
    logic [7:0]            pwm_mode_config_r;
    logic                  pmbus_mode_r;
    logic [PVC_IRQ_W-1:0]  irq_stat_r;
    logic [PVC_IRQ_W-1:0]  irq_mask_r;
    pvc_dphase_t           dp_r;
    logic                  hreadyout_r;
    logic [31:0]           hrdata_r;
    logic                  run_s1_r;
    logic                  run_s2_r;
    logic                  stp_s1_r;
    logic                  stp_s2_r;
    logic                  stp_d_r;
    logic [15:0]           ramp_r;
    logic                  rail_en_r;
    logic                  irq_r;
    logic                  ov_seen_r;
    logic                  uv_seen_r;

    logic                  busy;
    logic                  done;
    logic [15:0]           vout_max;
    logic                  capture;
    logic                  commit;
    logic                  wr;
    logic                  scale_start;
    logic                  scale_refused;
    logic                  rail_on;
    logic                  step_edge;
    logic [15:0]           vcmd_hi;
    logic [15:0]           wval;
    logic [15:0]           target;
    logic                  ov_now;
    logic                  uv_now;
    logic [31:0]           rd_val;
    logic [PVC_IRQ_W-1:0]  irq_set;

    assign capture = hsel && htrans[1] && hready;
    assign commit  = dp_r.valid && hreadyout_r;
    assign wr      = commit && dp_r.write;
    assign wval    = hwdata[15:0];
    assign rail_on = operation_r[PVC_OP_ON_BIT] && run_s2_r;
    assign scale_start   = wr && (dp_r.addr == PVC_OFS_SCALE_LOOP) && !rail_on;
    assign scale_refused = wr && (dp_r.addr == PVC_OFS_SCALE_LOOP) && rail_on;
    assign vcmd_hi = (vout_max < PVC_VCMD_MAX_MV) ? vout_max : PVC_VCMD_MAX_MV;
    assign step_edge = stp_s2_r && !stp_d_r;

    // ------------------------------------------------------------
    // Scale loop recalculation
    // ------------------------------------------------------------
    pvc_recalc #(
        .RECALC_CYCLES (RECALC_CYCLES),
        .FIXED_MAX     (FIXED_MAX)
    ) u_recalc (
        .clk        (clk),
        .rst_n      (rst_n),
        .start      (scale_start),
        .scale      (wval),
        .busy_r     (busy),
        .done_r     (done),
        .vout_max_r (vout_max)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_s1_r <= 1'b0;
            run_s2_r <= 1'b0;
            stp_s1_r <= 1'b0;
            stp_s2_r <= 1'b0;
            stp_d_r  <= 1'b0;
        end
        else
        begin
            run_s1_r <= run_pin;
            run_s2_r <= run_s1_r;
            stp_s1_r <= step_clk;
            stp_s2_r <= stp_s1_r;
            stp_d_r  <= stp_s2_r;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite data phase and wait states
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp_r        <= '0;
            hreadyout_r <= 1'b1;
        end
        else
        begin
            if (hready)
            begin
                dp_r.valid <= capture;
                dp_r.write <= hwrite;
                dp_r.addr  <= {haddr[7:2], 2'b00};
            end
            // Stall rather than drop: an output write stays on the bus
            // until the recalculation is over
            if (capture && hwrite && is_vout_reg({haddr[7:2], 2'b00}) &&
                (busy || scale_start))
                hreadyout_r <= 1'b0; // see [RULE_11]
            else if (!hreadyout_r && !busy)
                hreadyout_r <= 1'b1;
        end
    end

    always_comb
    begin
        rd_val = 32'h0000_0000;
        case ({haddr[7:2], 2'b00})
            PVC_OFS_OPERATION:  rd_val[7:0]  = operation_r;
            PVC_OFS_VOUT_CMD:   rd_val[15:0] = vout_cmd_r;
            PVC_OFS_SCALE_LOOP: rd_val[15:0] = scale_loop_r;
            PVC_OFS_MARGIN_HI:  rd_val[15:0] = margin_hi_r;
            PVC_OFS_MARGIN_LO:  rd_val[15:0] = margin_lo_r;
            PVC_OFS_OV_FAULT:   rd_val[15:0] = ov_fault_r;
            PVC_OFS_UV_FAULT:   rd_val[15:0] = uv_fault_r;
            PVC_OFS_OV_WARN:    rd_val[15:0] = ov_warn_r;
            PVC_OFS_UV_WARN:    rd_val[15:0] = uv_warn_r;
            PVC_OFS_TRAN_RATE:  rd_val[15:0] = tran_rate_r;
            PVC_OFS_PWM_MODE:   rd_val[7:0]  = pwm_mode_config_r;
            PVC_OFS_COMMON:
            begin
                rd_val[PVC_COM_BUSY_A_BIT] = busy; // see [RULE_09]
                rd_val[PVC_COM_BUSY_B_BIT] = busy; // see [RULE_18]
            end
            PVC_OFS_VOUT_MAX:   rd_val[15:0] = vout_max; // see [RULE_14]
            PVC_OFS_ABS_CEIL:   rd_val[15:0] = PVC_ABS_CEIL_MV;
            PVC_OFS_SENSE:      rd_val[15:0] = sense_adc; // see [RULE_07]
            PVC_OFS_IRQ_STAT:   rd_val[PVC_IRQ_W-1:0] = irq_stat_r;
            PVC_OFS_IRQ_MASK:   rd_val[PVC_IRQ_W-1:0] = irq_mask_r;
            default:            rd_val = 32'h0000_0000;
        endcase
    end

    // Read data settles for the data phase end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hrdata_r <= 32'h0000_0000;
        else
            hrdata_r <= rd_val;
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            operation_r       <= 8'h00;
            vout_cmd_r        <= PVC_FB_NOM_MV;
            scale_loop_r      <= PVC_SCALE_UNITY;
            margin_hi_r       <= PVC_MARGIN_HI_RST; // see [RULE_02]
            margin_lo_r       <= PVC_MARGIN_LO_RST;
            ov_fault_r        <= PVC_OV_FAULT_RST;
            uv_fault_r        <= PVC_UV_FAULT_RST;
            ov_warn_r         <= PVC_OV_WARN_RST; // see [RULE_03]
            uv_warn_r         <= PVC_UV_WARN_RST;
            tran_rate_r       <= PVC_RATE_RST;
            pwm_mode_config_r <= 8'h00; // see [RULE_05]
            irq_mask_r        <= '0;
        end
        else if (wr)
        begin
            case (dp_r.addr)
                PVC_OFS_OPERATION:  operation_r <= hwdata[7:0]; // see [RULE_01]
                PVC_OFS_VOUT_CMD:   vout_cmd_r  <= clamp(wval, PVC_VCMD_MIN_MV, vcmd_hi); // see [RULE_13]
                PVC_OFS_SCALE_LOOP:
                begin
                    if (!rail_on)
                        scale_loop_r <= wval;
                end
                PVC_OFS_MARGIN_HI:  margin_hi_r <= clamp(wval, 16'h0000, vout_max); // see [RULE_14]
                PVC_OFS_MARGIN_LO:  margin_lo_r <= clamp(wval, 16'h0000, vout_max);
                PVC_OFS_OV_FAULT:   ov_fault_r  <= clamp(wval, 16'h0000, vout_max);
                PVC_OFS_UV_FAULT:   uv_fault_r  <= clamp(wval, 16'h0000, vout_max);
                PVC_OFS_OV_WARN:    ov_warn_r   <= wval;
                PVC_OFS_UV_WARN:    uv_warn_r   <= wval;
                PVC_OFS_TRAN_RATE:  tran_rate_r <= wval;
                PVC_OFS_PWM_MODE:   pwm_mode_config_r <= hwdata[7:0]; // see [RULE_17]
                PVC_OFS_IRQ_MASK:   irq_mask_r  <= hwdata[PVC_IRQ_W-1:0];
                default:            operation_r <= operation_r;
            endcase
        end
    end

    // Direct control once a scale other than unity has been processed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pmbus_mode_r <= 1'b0;
        else if (done)
            pmbus_mode_r <= (scale_loop_r != PVC_SCALE_UNITY);
    end

    // ------------------------------------------------------------
    // Target ramp, one step per link clock rising edge
    // ------------------------------------------------------------
    always_comb
    begin
        target = pmbus_mode_r ? vout_cmd_r : PVC_FB_NOM_MV;
        case (operation_r[PVC_OP_MARGIN_LSB +: 2])
            PVC_MARGIN_LOW:  target = margin_lo_r; // see [RULE_01]
            PVC_MARGIN_HIGH: target = margin_hi_r;
            default:         target = pmbus_mode_r ? vout_cmd_r : PVC_FB_NOM_MV;
        endcase
        if (!rail_on || busy)
            target = 16'h0000;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ramp_r <= 16'h0000;
        else if (step_edge)
        begin
            // Rate is counted in the domain of the ramp itself
            if (ramp_r + tran_rate_r < target && ramp_r + tran_rate_r > ramp_r)
                ramp_r <= ramp_r + tran_rate_r; // see [RULE_04] [RULE_16]
            else if (ramp_r > target + tran_rate_r)
                ramp_r <= ramp_r - tran_rate_r;
            else
                ramp_r <= target;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rail_en_r <= 1'b0;
        else
            rail_en_r <= rail_on && !busy;
    end

    // ------------------------------------------------------------
    // Fault events and interrupt
    // ------------------------------------------------------------
    assign ov_now = rail_en_r && (sense_adc > ov_fault_r); // see [RULE_07]
    assign uv_now = rail_en_r && (ramp_r == target) && (sense_adc < uv_fault_r);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ov_seen_r <= 1'b0;
            uv_seen_r <= 1'b0;
        end
        else
        begin
            ov_seen_r <= ov_now;
            uv_seen_r <= uv_now;
        end
    end

    always_comb
    begin
        irq_set = '0;
        irq_set[PVC_IRQ_DONE_BIT]   = done;
        irq_set[PVC_IRQ_OV_BIT]     = ov_now && !ov_seen_r;
        irq_set[PVC_IRQ_UV_BIT]     = uv_now && !uv_seen_r;
        irq_set[PVC_IRQ_REFUSE_BIT] = scale_refused; // see [RULE_10]
    end

    // Set wins over a simultaneous write-one-to-clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_stat_r <= '0;
        else if (wr && dp_r.addr == PVC_OFS_IRQ_STAT)
            irq_stat_r <= (irq_stat_r & ~hwdata[PVC_IRQ_W-1:0]) | irq_set;
        else
            irq_stat_r <= irq_stat_r | irq_set;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_r <= 1'b0;
        else
            irq_r <= |(irq_stat_r & irq_mask_r);
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slave_phase   <= 1'b0;
            servo_en      <= 1'b0;
            ref_at_output <= 1'b0;
            ref_target    <= 16'h0000;
        end
        else
        begin
            slave_phase   <= pwm_mode_config_r[PVC_PWM_SLAVE_BIT]; // see [RULE_06]
            servo_en      <= pwm_mode_config_r[PVC_PWM_SERVO_BIT]; // see [RULE_17]
            ref_at_output <= pmbus_mode_r; // see [RULE_16]
            ref_target    <= ramp_r;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign rail_en   = rail_en_r;
    assign irq       = irq_r;

endmodule

// ---- pvc_checker.sv ----
`timescale 1ns/1ps
module pvc_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic        rail_en,
    input wire logic [15:0] ref_target,
    input wire logic        ref_at_output,
    input wire logic        slave_phase,
    input wire logic        servo_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_stall;
        $fell(hreadyout);
    endsequence
    a_resp_okay: assert property (!hresp)
        else $error("response not okay");
    a_read_nowait: assert property (s_take ##0 !hwrite |=> hreadyout)
        else $error("read was stalled");
    a_stall_cause: assert property (s_stall |-> $past(hsel && htrans[1] && hwrite))
        else $error("stall without write");
    a_stall_bound: assert property (s_stall |-> ##[1:40] hreadyout)
        else $error("stall too long");
    a_idle_ready: assert property (!$past(htrans[1]) && $past(hreadyout) |-> hreadyout)
        else $error("ready dropped when idle");
    a_reset_quiet: assert property ($rose(rst_n) |-> !rail_en && !irq && !servo_en
        && !slave_phase && ref_target == 16'h0000) else $error("reset values wrong");
    a_ref_ceiling: assert property (ref_target <= 16'h0EA6)
        else $error("reference above ceiling");
    a_mode_off: assert property ($changed(ref_at_output) |-> !rail_en)
        else $error("mode changed while running");
endmodule
bind pvc_ctrl pvc_checker u_chk (.*);

// ---- pvc_host_model.sv ----
`timescale 1ns/1ps
module pvc_host_model (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    output logic             stuck
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        stuck = 1'b0;
    end
    // Bounded waits; a hung slave raises stuck
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 99);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 99);
        q = hrdata;
        if (n >= 99) stuck <= 1'b1;
    endtask
endmodule

// ---- pmbus_vout_control_config_test.sv ----
`timescale 1ns/1ps
module pmbus_vout_control_config_test;
    import pvc_pkg::*;
    logic        clk, rst_n, run_pin, step_clk, stuck, hsel, hwrite, hreadyout, hresp;
    logic        irq, rail_en, ref_at_output, slave_phase, servo_en;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [15:0] sense_adc, ref_target;
    int          err_total, n_checks;
    pvc_ctrl #(.RECALC_CYCLES(20), .FIXED_MAX(1'b0)) u_dut (.*, .hready(hreadyout));
    pvc_host_model u_host (.*, .hready(hreadyout));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        step_clk = 1'b0;
        #3;
        forever #40 step_clk = ~step_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        u_host.xfer(a, 1'b0, 32'h0000_0000, q);
        chk($sformatf("reg %h", a), q, exp);
    endtask
    task automatic wait_ref(input logic [15:0] v);
        int n;
        for (n = 0; n < 2000 && ref_target !== v; n++) @(posedge clk);
        chk("ref_target", ref_target, v);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (stuck)
        begin
            err_total++;
            report_and_stop();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        run_pin = 1'b0;
        sense_adc = 16'h0190;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(PVC_OFS_MARGIN_HI, 32'h0000_01A4);
        rd(PVC_OFS_MARGIN_LO, 32'h0000_017C);
        rd(PVC_OFS_OV_FAULT, 32'h0000_01B8);
        rd(PVC_OFS_UV_FAULT, 32'h0000_0168);
        rd(PVC_OFS_OV_WARN, 32'h0000_FFFF);
        rd(PVC_OFS_UV_WARN, 32'h0000_0000);
        rd(PVC_OFS_PWM_MODE, 32'h0000_0000);
        rd(PVC_OFS_VOUT_MAX, 32'h0000_0EA6);
        rd(8'h7C, 32'h0000_0000);
        $display("test defaults done");
        wr(PVC_OFS_TRAN_RATE, 32'h0000_0040);
        run_pin <= 1'b1;
        wr(PVC_OFS_OPERATION, 32'h0000_00A0);
        wait_ref(16'h01A4);
        chk("ref_at_output", ref_at_output, 1'b0);
        wr(PVC_OFS_OPERATION, 32'h0000_0090);
        wait_ref(16'h017C);
        wr(PVC_OFS_SCALE_LOOP, 32'h0000_0080);
        rd(PVC_OFS_IRQ_STAT, 32'h0000_0008);
        chk("irq", irq, 1'b0);
        wr(PVC_OFS_IRQ_MASK, 32'h0000_0008);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b1);
        wr(PVC_OFS_IRQ_STAT, 32'h0000_0008);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1'b0);
        $display("test margin done");
        wr(PVC_OFS_OPERATION, 32'h0000_0000);
        wr(PVC_OFS_SCALE_LOOP, 32'h0000_0080);
        rd(PVC_OFS_COMMON, 32'h0000_0060);
        wr(PVC_OFS_VOUT_CMD, 32'h0000_0FA0);
        rd(PVC_OFS_COMMON, 32'h0000_0000);
        rd(PVC_OFS_IRQ_STAT, 32'h0000_0001);
        rd(PVC_OFS_VOUT_MAX, 32'h0000_06BD);
        rd(PVC_OFS_VOUT_CMD, 32'h0000_06BD);
        chk("ref_at_output", ref_at_output, 1'b1);
        wr(PVC_OFS_OPERATION, 32'h0000_0080);
        wait_ref(16'h06BD);
        wr(PVC_OFS_PWM_MODE, 32'h0000_0050);
        repeat (2) @(posedge clk);
        chk("servo_en", servo_en, 1'b1);
        chk("slave_phase", slave_phase, 1'b1);
        wr(PVC_OFS_VOUT_CMD, 32'h0000_0064);
        rd(PVC_OFS_VOUT_CMD, 32'h0000_012C);
        sense_adc <= 16'h0123;
        rd(PVC_OFS_SENSE, 32'h0000_0123);
        $display("test direct done");
        report_and_stop();
    end
endmodule
